// ### hw/scc_defs.svh
// Offsets, field positions, reset values for the switch capability config bank
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH
`define SCC_OFF_MSI_UADDR 8'h54
`define SCC_OFF_MSI_DATA 8'h58
`define SCC_OFF_PD 8'h5C
`define SCC_OFF_PD_DATA 8'h60
`define SCC_OFF_VENDOR 8'h64
`define SCC_OFF_SCR0 8'h68
`define SCC_OFF_SCR1 8'h6C
`define SCC_OFF_TIMER 8'h70
`define SCC_OFF_MSI_CTRL 8'h4C
`define SCC_PD_CAP_ID 8'h03
`define SCC_PD_NEXT 8'h64
`define SCC_VEND_CAP_ID 8'h09
`define SCC_VEND_NEXT 8'hB0
`define SCC_VEND_LEN 16'h0034
`define SCC_SCR0_RST 32'h0400_1060
`define SCC_SCR1_RST 32'h0400_0800
`define SCC_ZERO32 32'h0000_0000
`define SCC_MSI_DATA_W 16
`define SCC_PD_IDX_LSB 18
`define SCC_PD_IDX_MSB 23
`define SCC_PD_DIR_BIT 31
`define SCC_RPL_MSB 11
`define SCC_RPL_EN_BIT 12
`define SCC_PM_DIS_BIT 13
`define SCC_MSI_DIS_BIT 14
`define SCC_ACK_LSB 16
`define SCC_ACK_MSB 29
`define SCC_ACK_EN_BIT 30
`define SCC_VGA_BIT 31
`define SCC_MSI64_BIT 23
`define SCC_RPL_W 12
`define SCC_ACK_W 14
`define SCC_MSI64_RST 1'b1
`define SCC_VGA_RST 1'b1
`endif

// ### hw/scc_pkg.sv
// Types shared by the switch capability config bank
`default_nettype none
package scc_pkg;
  // One configuration access from the host
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } scc_cfg_req_type;
  // Default values presented by SMBus or EEPROM auto-load
  typedef struct packed {
    logic load;
    logic [11:0] rpl_val;
    logic rpl_en;
    logic pm_dis;
    logic msi_dis;
    logic [13:0] ack_val;
    logic ack_en;
  } scc_dflt_type;
  // Product-data EEPROM engine states
  typedef enum logic [1:0] {
    SCC_PD_IDLE = 2'b00,
    SCC_PD_BUSY = 2'b01,
    SCC_PD_DONE = 2'b11
  } scc_pd_state_type;
endpackage
`default_nettype wire

// ### hw/scc_config_regs.sv
// Capability configuration register bank of one switch port
//
// Summary of operation
// - The upper message address word is 32-bit read-write, resets to zero, used when 64-bit addressing is reported.
// - The message data is 16-bit read-write in the low half, reset to zero, upper half reserved.
// - The product-data header reads identifier 03h and next pointer 64h, read-only.
// - A six-bit read-write dword index at bits 23:18 resets to zero and addresses the next EEPROM cycle.
// - Writing 0 to bit 31 starts an EEPROM read, and bit 31 becomes 1 when it completes.
// - Writing 1 to bit 31 starts an EEPROM write, and bit 31 becomes 0 when it completes.
// - The vendor header reads identifier 09h in bits 7:0.
// - The vendor header next pointer reads B0h.
// - The vendor header bits 31:16 read the structure length 0034h.
// - With bit 12 set, the 12-bit user replay value replaces the built-in time-out; both reset to zero.
// - With bit 30 set, the 14-bit user ack value replaces the built-in latency; both reset to zero.
// - Timer override and capability-disable defaults can be replaced via SMBus or EEPROM auto-load.
// - Read-only bit 31 of the timer word resets to 1 and enables legacy VGA decode.
// - Two test words reset to 0400_1060h and 0400_0800h.
// - A read-only bit reporting 64-bit message address capability reads 1.
`timescale 1ns/100ps
`default_nettype none
`include "scc_defs.svh"
module scc_config_regs #(
  parameter int RPL_W = `SCC_RPL_W,
  parameter int ACK_W = `SCC_ACK_W,
  parameter logic [RPL_W-1:0] RPL_BUILTIN = '0,
  parameter logic [ACK_W-1:0] ACK_BUILTIN = '0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire scc_pkg::scc_cfg_req_type cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  input wire scc_pkg::scc_dflt_type dflt,
  output logic ee_req,
  output logic ee_write,
  output logic [5:0] ee_dword_index,
  input wire logic ee_done,
  output logic [RPL_W-1:0] replay_timeout,
  output logic [ACK_W-1:0] ack_latency,
  output logic msi64_capable,
  output logic msi_upper_active,
  output logic vga_decode_en,
  output logic pm_cap_disable,
  output logic msi_cap_disable
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;
  // Release through two flops so all state leaves reset on one edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-enable merge used by every writable word
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input scc_pkg::scc_cfg_req_type q,
                               input logic [7:0] off);
    return q.wr && (q.addr == off);
  endfunction

  logic [31:0] msi_uaddr_ff;
  logic [15:0] msi_data_ff;
  logic [5:0] pd_index_ff;
  logic product_data_direction_flag_ff;
  logic [31:0] scr0_ff;
  logic [31:0] scr1_ff;
  logic [RPL_W-1:0] rpl_val_ff;
  logic rpl_en_ff;
  logic pm_dis_ff;
  logic msi_dis_ff;
  logic [ACK_W-1:0] ack_val_ff;
  logic ack_en_ff;
  scc_pkg::scc_pd_state_type pd_state_ff;
  logic [31:0] wr_merged;
  logic [31:0] timer_word;
  logic [31:0] pd_word;
  logic [31:0] msi_data_merged;
  logic [31:0] timer_merged;
  logic [31:0] msi_ctrl_word;

  // ----------------------------------------------------------------
  // Message-signalled interrupt words
  // ----------------------------------------------------------------
  // Upper address is full 32-bit RW
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      msi_uaddr_ff <= `SCC_ZERO32;
    end else if (hit(cfg_req, `SCC_OFF_MSI_UADDR)) begin
      msi_uaddr_ff <= merge_be(msi_uaddr_ff, cfg_req.wdata, cfg_req.be);
    end
  end

  // Only the low half is stored; upper bits are never kept
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      msi_data_ff <= '0;
    end else if (hit(cfg_req, `SCC_OFF_MSI_DATA)) begin
      msi_data_ff <= msi_data_merged[`SCC_MSI_DATA_W-1:0];
    end
  end

  // Capability bit is hardwired; upper word only matters when it is set
  assign msi64_capable = `SCC_MSI64_RST;
  assign msi_upper_active = msi64_capable && (msi_uaddr_ff != `SCC_ZERO32);

  // ----------------------------------------------------------------
  // Product-data EEPROM handshake
  // ----------------------------------------------------------------
  // Merged write words; a function result cannot be part-selected directly
  assign wr_merged = merge_be(pd_word, cfg_req.wdata, cfg_req.be);
  assign msi_data_merged = merge_be({16'h0000, msi_data_ff}, cfg_req.wdata,
                                    cfg_req.be);
  assign timer_merged = merge_be(timer_word, cfg_req.wdata, cfg_req.be);

  // Index may be changed any time; a new write while busy restarts nothing
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pd_index_ff <= '0;
    end else if (hit(cfg_req, `SCC_OFF_PD) && cfg_req.be[2]) begin
      pd_index_ff <= wr_merged[`SCC_PD_IDX_MSB:`SCC_PD_IDX_LSB];
    end
  end

  // Byte 3 write launches a cycle when idle; completion flips the flag, a byte 3 write while busy is ignored
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pd_state_ff <= scc_pkg::SCC_PD_IDLE;
      product_data_direction_flag_ff <= 1'b0;
    end else begin
      unique case (pd_state_ff)
        scc_pkg::SCC_PD_IDLE: begin
          if (hit(cfg_req, `SCC_OFF_PD) && cfg_req.be[3]) begin
            product_data_direction_flag_ff <= cfg_req.wdata[`SCC_PD_DIR_BIT];
            pd_state_ff <= scc_pkg::SCC_PD_BUSY;
          end
        end
        scc_pkg::SCC_PD_BUSY: begin
          if (ee_done) begin
            // Read completes to 1, write completes to 0
            product_data_direction_flag_ff <= !product_data_direction_flag_ff;
            pd_state_ff <= scc_pkg::SCC_PD_DONE;
          end
        end
        scc_pkg::SCC_PD_DONE: begin
          pd_state_ff <= scc_pkg::SCC_PD_IDLE;
        end
        default: begin
          pd_state_ff <= scc_pkg::SCC_PD_IDLE;
        end
      endcase
    end
  end

  assign ee_req = (pd_state_ff == scc_pkg::SCC_PD_BUSY);
  assign ee_write = product_data_direction_flag_ff;
  assign ee_dword_index = pd_index_ff;

  // ----------------------------------------------------------------
  // Test scratch words
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      scr0_ff <= `SCC_SCR0_RST;
      scr1_ff <= `SCC_SCR1_RST;
    end else begin
      if (hit(cfg_req, `SCC_OFF_SCR0)) begin
        scr0_ff <= merge_be(scr0_ff, cfg_req.wdata, cfg_req.be);
      end
      if (hit(cfg_req, `SCC_OFF_SCR1)) begin
        scr1_ff <= merge_be(scr1_ff, cfg_req.wdata, cfg_req.be);
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer overrides and capability disables
  // ----------------------------------------------------------------
  // Default load overrides a host write in the same cycle
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rpl_val_ff <= '0;
      rpl_en_ff <= 1'b0;
      ack_val_ff <= '0;
      ack_en_ff <= 1'b0;
    end else if (dflt.load) begin
      rpl_val_ff <= dflt.rpl_val[RPL_W-1:0];
      rpl_en_ff <= dflt.rpl_en;
      ack_val_ff <= dflt.ack_val[ACK_W-1:0];
      ack_en_ff <= dflt.ack_en;
    end else if (hit(cfg_req, `SCC_OFF_TIMER)) begin
      rpl_val_ff <= timer_merged[RPL_W-1:0];
      rpl_en_ff <= timer_merged[`SCC_RPL_EN_BIT];
      ack_val_ff <= timer_merged[`SCC_ACK_MSB:`SCC_ACK_LSB];
      ack_en_ff <= timer_merged[`SCC_ACK_EN_BIT];
    end
  end

  // Host writes never touch the disables
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pm_dis_ff <= 1'b0;
      msi_dis_ff <= 1'b0;
    end else if (dflt.load) begin
      pm_dis_ff <= dflt.pm_dis;
      msi_dis_ff <= dflt.msi_dis;
    end
  end

  // Override selection feeding the link layer
  assign replay_timeout = rpl_en_ff ? rpl_val_ff : RPL_BUILTIN;
  assign ack_latency = ack_en_ff ? ack_val_ff : ACK_BUILTIN;
  assign vga_decode_en = `SCC_VGA_RST;
  assign pm_cap_disable = pm_dis_ff;
  assign msi_cap_disable = msi_dis_ff;

  // ----------------------------------------------------------------
  // Read assembly
  // ----------------------------------------------------------------
  always_comb begin
    timer_word = '0;
    timer_word[`SCC_RPL_MSB:0] = rpl_val_ff;
    timer_word[`SCC_RPL_EN_BIT] = rpl_en_ff;
    timer_word[`SCC_PM_DIS_BIT] = pm_dis_ff;
    timer_word[`SCC_MSI_DIS_BIT] = msi_dis_ff;
    timer_word[`SCC_ACK_MSB:`SCC_ACK_LSB] = ack_val_ff;
    timer_word[`SCC_ACK_EN_BIT] = ack_en_ff;
    timer_word[`SCC_VGA_BIT] = vga_decode_en;
  end

  // Only the 64-bit capable flag of the control word is modelled
  always_comb begin
    msi_ctrl_word = '0;
    msi_ctrl_word[`SCC_MSI64_BIT] = msi64_capable;
  end

  always_comb begin
    pd_word = '0;
    pd_word[7:0] = `SCC_PD_CAP_ID;
    pd_word[15:8] = `SCC_PD_NEXT;
    pd_word[`SCC_PD_IDX_MSB:`SCC_PD_IDX_LSB] = pd_index_ff;
    pd_word[`SCC_PD_DIR_BIT] = product_data_direction_flag_ff;
  end

  // Registered read data; unknown offsets read zero
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      cfg_rdata <= `SCC_ZERO32;
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_req.rd || cfg_req.wr;
      if (cfg_req.rd) begin
        unique case (cfg_req.addr)
          `SCC_OFF_MSI_CTRL: cfg_rdata <= msi_ctrl_word;
          `SCC_OFF_MSI_UADDR: cfg_rdata <= msi_uaddr_ff;
          `SCC_OFF_MSI_DATA: cfg_rdata <= {16'h0000, msi_data_ff};
          `SCC_OFF_PD: cfg_rdata <= pd_word;
          `SCC_OFF_VENDOR: cfg_rdata <= {`SCC_VEND_LEN, `SCC_VEND_NEXT,
                                         `SCC_VEND_CAP_ID};
          `SCC_OFF_SCR0: cfg_rdata <= scr0_ff;
          `SCC_OFF_SCR1: cfg_rdata <= scr1_ff;
          `SCC_OFF_TIMER: cfg_rdata <= timer_word;
          default: cfg_rdata <= `SCC_ZERO32;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence pd_launch_s;
    pd_state_ff == scc_pkg::SCC_PD_IDLE && hit(cfg_req, `SCC_OFF_PD)
      && cfg_req.be[3];
  endsequence

  sequence pd_finish_s;
    pd_state_ff == scc_pkg::SCC_PD_BUSY && ee_done;
  endsequence

  pd_read_done_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    pd_finish_s and (product_data_direction_flag_ff == 1'b0)
      |=> product_data_direction_flag_ff == 1'b1)
    else $error("read completion did not set direction flag");

  pd_write_done_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    pd_finish_s and (product_data_direction_flag_ff == 1'b1)
      |=> product_data_direction_flag_ff == 1'b0)
    else $error("write completion did not clear direction flag");

  pd_launch_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    pd_launch_s |=> ee_req && ee_write == $past(cfg_req.wdata[`SCC_PD_DIR_BIT]))
    else $error("eeprom cycle not launched with written direction");

  vendor_hdr_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    cfg_req.rd && cfg_req.addr == `SCC_OFF_VENDOR
      |=> cfg_rdata == {`SCC_VEND_LEN, `SCC_VEND_NEXT, `SCC_VEND_CAP_ID})
    else $error("vendor header read wrong");

  pd_hdr_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    cfg_req.rd && cfg_req.addr == `SCC_OFF_PD
      |=> cfg_rdata[15:0] == {`SCC_PD_NEXT, `SCC_PD_CAP_ID})
    else $error("product data header read wrong");

  replay_sel_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    replay_timeout == (rpl_en_ff ? rpl_val_ff : RPL_BUILTIN))
    else $error("replay timeout selection wrong");

  ack_sel_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    ack_en_ff |-> ack_latency == ack_val_ff)
    else $error("ack latency override not used");

  msi_data_rsvd_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    cfg_req.rd && cfg_req.addr == `SCC_OFF_MSI_DATA
      |=> cfg_rdata[31:16] == 16'h0000)
    else $error("message data reserved half not zero");

  dis_hold_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    !dflt.load |=> $stable(pm_dis_ff) && $stable(msi_dis_ff))
    else $error("capability disable changed without default load");

  vga_bit_a: assert property (@(posedge core_clk) disable iff (!rst_sync_ff)
    cfg_req.rd && cfg_req.addr == `SCC_OFF_TIMER |=> cfg_rdata[`SCC_VGA_BIT])
    else $error("vga decode bit not read as one");

endmodule
`default_nettype wire

// ### test/scc_ee_model.sv
// Behavioural serial EEPROM responder for the product-data engine
`timescale 1ns/100ps
`default_nettype none
module scc_ee_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ee_req,
  input wire logic [7:0] delay,
  output logic ee_done
);
  logic [7:0] cnt_ff;
  logic seen_ff;

  // ----------------------------------------
  // Cycle completion
  // ----------------------------------------
  // One done pulse per request, after delay cycles; seen_ff stops a
  // second pulse while the bank is still dropping its request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
      seen_ff <= 1'b0;
      ee_done <= 1'b0;
    end else begin
      ee_done <= 1'b0;
      if (!ee_req) begin
        cnt_ff <= 8'h00;
        seen_ff <= 1'b0;
      end else if (!seen_ff) begin
        if (cnt_ff == delay) begin
          ee_done <= 1'b1;
          seen_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### test/tb_switch_capability_config_regs.sv
// Self-checking bench for the capability configuration register bank
`timescale 1ns/100ps
`default_nettype none
module tb_switch_capability_config_regs;
  logic core_clk;
  logic rst_n;
  scc_pkg::scc_cfg_req_type cfg_req;
  scc_pkg::scc_dflt_type dflt;
  logic [31:0] cfg_rdata;
  logic cfg_ack, ee_req, ee_write, ee_done;
  logic [5:0] ee_dword_index;
  logic [11:0] replay_timeout;
  logic [13:0] ack_latency;
  logic msi64_capable, msi_upper_active, vga_decode_en;
  logic pm_cap_disable, msi_cap_disable;
  logic [7:0] ee_delay;
  logic [31:0] lfsr;
  int err_count, n_tests;
  logic [7:0] addr_tbl [8];
  logic [31:0] mask_tbl [8];
  logic [31:0] exp_tbl [8];

  scc_config_regs #(.RPL_BUILTIN(12'h5a5), .ACK_BUILTIN(14'h1234)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .dflt(dflt),
    .ee_req(ee_req), .ee_write(ee_write),
    .ee_dword_index(ee_dword_index), .ee_done(ee_done),
    .replay_timeout(replay_timeout), .ack_latency(ack_latency),
    .msi64_capable(msi64_capable), .msi_upper_active(msi_upper_active),
    .vga_decode_en(vga_decode_en), .pm_cap_disable(pm_cap_disable),
    .msi_cap_disable(msi_cap_disable));

  scc_ee_model ee_u (.core_clk(core_clk), .rst_n(rst_n), .ee_req(ee_req),
    .delay(ee_delay), .ee_done(ee_done));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Galois shift register, fixed seed keeps runs repeatable
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h0040_0007 : 32'h0000_0000);
    return lfsr;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, n, m,
                                        input logic [3:0] be);
    logic [31:0] bm;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & m;
    return (o & ~bm) | (n & bm);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // One access: request held for one edge, answer one cycle later
  task automatic cfg(input logic rd, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d);
    @(posedge core_clk);
    cfg_req <= '{rd: rd, wr: !rd, addr: a, be: be, wdata: d};
    @(posedge core_clk);
    cfg_req <= '0;
    #1;
    chk({31'h0, cfg_ack}, 32'h1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    cfg(1'b1, a, 4'h0, 32'h0);
    chk(cfg_rdata, e);
  endtask

  // Bounded wait for the engine request level
  task automatic wait_req(input logic v);
    int k;
    k = 0;
    while (ee_req !== v && k < 100) begin
      @(posedge core_clk);
      #1;
      k++;
    end
  endtask

  // Product-data cycle; a direction write to byte 3 while busy is ignored
  task automatic pd_op(input logic dir, input logic [5:0] idx,
                       input logic [7:0] dly);
    ee_delay <= dly;
    cfg(1'b0, 8'h5c, 4'b1100, {dir, 7'h0, idx, 18'h0});
    wait_req(1'b1);
    chk({31'h0, ee_req}, 32'h1);
    chk({31'h0, ee_write}, {31'h0, dir});
    chk({26'h0, ee_dword_index}, {26'h0, idx});
    if (dly > 8'h00) begin
      cfg(1'b0, 8'h5c, 4'b1000, {~dir, 31'h0});
      rd_chk(8'h5c, {dir, 7'h0, idx, 2'h0, 16'h6403});
    end
    wait_req(1'b0);
    rd_chk(8'h5c, {~dir, 7'h0, idx, 2'h0, 16'h6403});
  endtask

  task automatic check_outputs();
    logic [31:0] t;
    t = exp_tbl[5];
    chk({20'h0, replay_timeout}, {20'h0, t[12] ? t[11:0] : 12'h5a5});
    chk({18'h0, ack_latency}, {18'h0, t[30] ? t[29:16] : 14'h1234});
    chk({31'h0, msi_upper_active}, {31'h0, exp_tbl[0] != 32'h0});
    chk({31'h0, msi64_capable}, 32'h1);
    chk({31'h0, vga_decode_en}, 32'h1);
    chk({30'h0, msi_cap_disable, pm_cap_disable}, {30'h0, t[14:13]});
  endtask

  task automatic test_done();
    $display("counts: checks=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog, well beyond the expected thousand or so cycles
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    test_done();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    logic [3:0] be;
    rst_n = 1'b0;
    cfg_req = '0;
    dflt = '0;
    ee_delay = 8'h00;
    lfsr = 32'h9d78_19f6;
    err_count = 0;
    n_tests = 0;
    addr_tbl = '{8'h54, 8'h58, 8'h64, 8'h68, 8'h6c, 8'h70, 8'h80, 8'h4c};
    mask_tbl = '{32'hffff_ffff, 32'h0000_ffff, 32'h0000_0000, 32'hffff_ffff,
                 32'hffff_ffff, 32'h7fff_1fff, 32'h0000_0000, 32'h0000_0000};
    exp_tbl = '{32'h0000_0000, 32'h0000_0000, 32'h0034_b009, 32'h0400_1060,
                32'h0400_0800, 32'h8000_0000, 32'h0000_0000, 32'h0080_0000};
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    // Reset values of every word
    for (int i = 0; i < 8; i++) begin
      rd_chk(addr_tbl[i], exp_tbl[i]);
    end
    rd_chk(8'h5c, 32'h0000_6403);
    check_outputs();
    $display("test reset values done");
    // Random byte-enabled writes, read-only and reserved bits must hold
    for (int r = 0; r < 24; r++) begin
      for (int i = 0; i < 8; i++) begin
        v = rnd();
        be = (r < 2) ? 4'hf : 4'(rnd());
        cfg(1'b0, addr_tbl[i], be, v);
        exp_tbl[i] = merge(exp_tbl[i], v, mask_tbl[i], be);
      end
      if (r % 4 == 3) begin
        v = rnd();
        @(posedge core_clk);
        dflt <= '{load: 1'b1, rpl_val: v[11:0], rpl_en: v[12], pm_dis: v[13],
                  msi_dis: v[14], ack_val: v[29:16], ack_en: v[30]};
        @(posedge core_clk);
        dflt <= '0;
        exp_tbl[5] = {1'b1, v[30:16], 1'b0, v[14:0]};
      end
      for (int i = 0; i < 8; i++) begin
        rd_chk(addr_tbl[i], exp_tbl[i]);
      end
      check_outputs();
    end
    $display("test random writes done");
    // Product-data reads and writes, prompt and slow
    for (int d = 0; d < 4; d++) begin
      v = rnd();
      pd_op(d[0], v[5:0], d[1] ? 8'h0c : 8'h00);
    end
    pd_op(1'b0, 6'h3f, 8'h03);
    pd_op(1'b1, 6'h00, 8'h00);
    $display("test product data done");
    test_done();
  end
endmodule
`default_nettype wire
